// ### verilog/cmtp_pkg.sv
// Package for the clock mode and timer pin block.
// Assumes one 125 MHz system clock; no registers reached by software over a bus.
package cmtp_pkg;
  localparam int CMTP_MODE_W = 3;
  localparam logic [2:0] CMTP_MODE_RST = 3'h0;
  localparam int CMTP_CLK_PERIOD_NS = 8;
  // Machine cycle length in system clocks; the machine clock output toggles at half of it.
  localparam int CMTP_MACH_DIV = 2;
  localparam logic [7:0] CMTP_MACH_DIV_M1 = 8'(CMTP_MACH_DIV - 1);
  localparam logic [7:0] CMTP_MACH_HALF = 8'(CMTP_MACH_DIV / 2);
  localparam logic [7:0] CMTP_CNT_RST = 8'h00;
endpackage

// ### verilog/cmtp_pins.sv
// Clock mode capture, machine clock output and timer pulse pins.
// Assumes all inputs synchronous to CLK; the board resolves three-state pins from enables.
// Functional notes
// - Machine clock output runs at machine-cycle rate, rising edge starts each cycle.
// - Machine clock output is undriven while emulation-off input is low.
// - While reset is low, mode-select inputs are captured into the clock mode register.
// - After reset, software may change mode; mode-select inputs are then ignored.
// - External clock input is the clock source when internal oscillator unused.
// - Timer zero underflow gives a one machine-cycle pulse on first timer output.
// - First timer output is undriven while emulation-off input is low.
// - Timer one underflow gives a one machine-cycle pulse on second timer output.
// - Timer one pulse reaches the shared pin only while host port is disabled.
// - Shared timer/host-interrupt output is undriven while emulation-off input is low.
`timescale 1ns/1ns
module cmtp_pins
  import cmtp_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CLOCK_MODE_SEL_A,
  input wire logic CLOCK_MODE_SEL_B,
  input wire logic CLOCK_MODE_SEL_C,
  input wire logic MODE_WR,
  input wire logic [2:0] MODE_WDATA,
  input wire logic USE_INT_OSC,
  input wire logic EXT_CLOCK_IN,
  input wire logic OSC_CORE_IN,
  input wire logic TIMER_ZERO_UFLOW,
  input wire logic TIMER_ONE_UFLOW,
  input wire logic HOST_PORT_EN,
  input wire logic HOST_INTERRUPT_IN,
  input wire logic EMULATION_OFF_N,
  output logic [2:0] CLOCK_MODE,
  output logic CLOCK_SOURCE,
  output logic CRYSTAL_DRIVE_OUT,
  output logic MACHINE_CLOCK_OUT,
  output logic MACHINE_CLOCK_OE,
  output logic MACHINE_TICK,
  output logic TIMER_ZERO_PULSE_OUT,
  output logic TIMER_ZERO_OE,
  output logic TIMER_ONE_PULSE_OUT,
  output logic TIMER_ONE_OE
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] mode;
    logic [7:0] cnt;
    logic mclk;
    logic tick;
    logic src;
    logic xdrv;
    logic pend0;
    logic pend1;
    logic t0;
    logic t1;
    logic oe;
    logic t1oe;
    logic t1pin;
  } cmtp_state_t;

  cmtp_state_t st;
  cmtp_state_t next_st;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == CMTP_MACH_DIV_M1) begin
      next_st.cnt = CMTP_CNT_RST;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
    next_st.mclk = (next_st.cnt < CMTP_MACH_HALF) || (CMTP_MACH_DIV == 1);
    if (!RESETN) begin
      next_st.mode = {CLOCK_MODE_SEL_C, CLOCK_MODE_SEL_B, CLOCK_MODE_SEL_A};
    end else if (MODE_WR) begin
      next_st.mode = MODE_WDATA;
    end
    next_st.src = USE_INT_OSC ? OSC_CORE_IN : EXT_CLOCK_IN;
    next_st.xdrv = USE_INT_OSC & ~OSC_CORE_IN;
    // Underflows wait for the next machine edge, then last exactly one machine cycle.
    if (TIMER_ZERO_UFLOW) next_st.pend0 = 1'b1;
    if (TIMER_ONE_UFLOW) next_st.pend1 = 1'b1;
    if (st.tick) begin
      next_st.t0 = st.pend0 | TIMER_ZERO_UFLOW;
      next_st.pend0 = 1'b0;
      next_st.t1 = st.pend1 | TIMER_ONE_UFLOW;
      next_st.pend1 = 1'b0;
    end
    next_st.oe = EMULATION_OFF_N;
    next_st.t1oe = EMULATION_OFF_N;
    // The shared pin takes one extra flop after the host port select.
    next_st.t1pin = HOST_PORT_EN ? HOST_INTERRUPT_IN : st.t1;
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st <= '0;
      st.mode <= next_st.mode;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  // Each pin is a flop output; the board resolves three-state pins from their enables.
  assign CLOCK_MODE = st.mode;
  assign CLOCK_SOURCE = st.src;
  assign CRYSTAL_DRIVE_OUT = st.xdrv;
  assign MACHINE_CLOCK_OUT = st.mclk;
  assign MACHINE_CLOCK_OE = st.oe;
  assign MACHINE_TICK = st.tick;
  assign TIMER_ZERO_PULSE_OUT = st.t0;
  assign TIMER_ZERO_OE = st.oe;
  assign TIMER_ONE_PULSE_OUT = st.t1pin;
  assign TIMER_ONE_OE = st.t1oe;

  // ----------------------------------------
  // Checks: clock mode
  // ----------------------------------------
  mode_capture_a: assert property (@(posedge CLK) !RESETN |=>
    CLOCK_MODE == $past({CLOCK_MODE_SEL_C, CLOCK_MODE_SEL_B, CLOCK_MODE_SEL_A}))
    else $error("mode not captured in reset");

  mode_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !MODE_WR && $past(RESETN) |=> $stable(CLOCK_MODE))
    else $error("mode changed without write");

  mode_write_a: assert property (@(posedge CLK) disable iff (!RESETN)
    MODE_WR |=> CLOCK_MODE == $past(MODE_WDATA))
    else $error("mode write lost");

  strap_ignore_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !MODE_WR && $changed({CLOCK_MODE_SEL_C, CLOCK_MODE_SEL_B, CLOCK_MODE_SEL_A})
    |=> $stable(CLOCK_MODE))
    else $error("mode followed straps after reset");

  // ----------------------------------------
  // Checks: machine clock
  // ----------------------------------------
  mclk_rate_a: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(MACHINE_CLOCK_OUT) |-> ##CMTP_MACH_DIV $rose(MACHINE_CLOCK_OUT))
    else $error("machine clock period wrong");

  tick_align_a: assert property (@(posedge CLK) disable iff (!RESETN)
    MACHINE_TICK == $rose(MACHINE_CLOCK_OUT))
    else $error("machine tick off the rising edge");

  // ----------------------------------------
  // Checks: timer pulses
  // ----------------------------------------
  // A take is a machine boundary with an underflow pending or arriving.
  sequence t0_take_s;
    st.tick && (st.pend0 || TIMER_ZERO_UFLOW);
  endsequence

  sequence t0_high_s;
    TIMER_ZERO_PULSE_OUT [*2];
  endsequence

  sequence t1_take_s;
    st.tick && (st.pend1 || TIMER_ONE_UFLOW);
  endsequence

  t0_pulse_a: assert property (@(posedge CLK) disable iff (!RESETN)
    t0_take_s |=> t0_high_s ##1
    (TIMER_ZERO_PULSE_OUT == ($past(st.pend0) || $past(TIMER_ZERO_UFLOW))))
    else $error("timer zero pulse width wrong");

  t0_quiet_a: assert property (@(posedge CLK) disable iff (!RESETN)
    st.tick && !st.pend0 && !TIMER_ZERO_UFLOW |=> !TIMER_ZERO_PULSE_OUT)
    else $error("timer zero pulse without underflow");

  t0_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !st.tick |=> $stable(TIMER_ZERO_PULSE_OUT))
    else $error("timer zero changed inside a machine cycle");

  t1_pulse_a: assert property (@(posedge CLK) disable iff (!RESETN)
    t1_take_s |=> st.t1 [*2])
    else $error("timer one pulse missing");

  t1_quiet_a: assert property (@(posedge CLK) disable iff (!RESETN)
    st.tick && !st.pend1 && !TIMER_ONE_UFLOW |=> !st.t1)
    else $error("timer one pulse without underflow");

  t1_timer_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !HOST_PORT_EN |=> TIMER_ONE_PULSE_OUT == $past(st.t1))
    else $error("shared pin not timer one");

  t1_share_a: assert property (@(posedge CLK) disable iff (!RESETN)
    HOST_PORT_EN |=> TIMER_ONE_PULSE_OUT == $past(HOST_INTERRUPT_IN))
    else $error("shared pin not host interrupt");

  // ----------------------------------------
  // Checks: pin drivers and clock source
  // ----------------------------------------
  mclk_off_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !EMULATION_OFF_N |=> !MACHINE_CLOCK_OE && !TIMER_ZERO_OE && !TIMER_ONE_OE)
    else $error("pin driven while off");

  pin_on_a: assert property (@(posedge CLK) disable iff (!RESETN)
    EMULATION_OFF_N |=> MACHINE_CLOCK_OE && TIMER_ZERO_OE && TIMER_ONE_OE)
    else $error("pin floated while on");

  src_sel_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !USE_INT_OSC |=> CLOCK_SOURCE == $past(EXT_CLOCK_IN))
    else $error("external clock not selected");

  src_int_a: assert property (@(posedge CLK) disable iff (!RESETN)
    USE_INT_OSC |=> CLOCK_SOURCE == $past(OSC_CORE_IN)
    && CRYSTAL_DRIVE_OUT == !$past(OSC_CORE_IN))
    else $error("internal oscillator not selected");

  xdrv_idle_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !USE_INT_OSC |=> !CRYSTAL_DRIVE_OUT)
    else $error("crystal drive active with external clock");

endmodule

// ### tb/cmtp_board.sv
// Board-side view of one three-state pin of the clock and timer group.
// Assumes the pin has no pull; a released pin shows the inverse of its last driven level.
`timescale 1ns/1ns
module cmtp_board (
  input wire logic clk,
  input wire logic level,
  input wire logic oe,
  output logic pin
);
  logic last = 1'b0;
  always @(posedge clk) if (oe) last <= level;
  assign pin = oe ? level : ~last;
endmodule

// ### tb/tb_clock_mode_and_timer_pins.sv
// Self-checking bench for the clock mode and timer pin block.
// Assumes the package constants; inputs change at the falling edge of CLK.
`timescale 1ns/1ns
module tb_clock_mode_and_timer_pins;
  import cmtp_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, osc = 1'b1, ext = 1'b0, osc_in = 1'b0;
  logic u0 = 1'b0, u1 = 1'b0, hen = 1'b0, hin = 1'b1, emu_n = 1'b1;
  logic [2:0] sel = 3'h5, wd = 3'h0, mode;
  logic src, xd, mco, mcoe, tick, t0, t0oe, t1, t1oe, pin0;
  int n_mismatch = 0, total_checks = 0, cyc = 0, w, v, k, seed = 32'hD2DF;
  int m_n = 0;
  logic [2:0] m_mode;
  logic m_oe = 1'b0;
  cmtp_pins dut (.CLK(clk), .RESETN(resetn), .CLOCK_MODE_SEL_A(sel[0]),
    .CLOCK_MODE_SEL_B(sel[1]), .CLOCK_MODE_SEL_C(sel[2]), .MODE_WR(wr), .MODE_WDATA(wd),
    .USE_INT_OSC(osc), .EXT_CLOCK_IN(ext), .OSC_CORE_IN(osc_in), .TIMER_ZERO_UFLOW(u0),
    .TIMER_ONE_UFLOW(u1), .HOST_PORT_EN(hen), .HOST_INTERRUPT_IN(hin),
    .EMULATION_OFF_N(emu_n), .CLOCK_MODE(mode), .CLOCK_SOURCE(src), .CRYSTAL_DRIVE_OUT(xd),
    .MACHINE_CLOCK_OUT(mco), .MACHINE_CLOCK_OE(mcoe), .MACHINE_TICK(tick),
    .TIMER_ZERO_PULSE_OUT(t0), .TIMER_ZERO_OE(t0oe), .TIMER_ONE_PULSE_OUT(t1),
    .TIMER_ONE_OE(t1oe));
  cmtp_board board0 (.clk(clk), .level(t0), .oe(t0oe), .pin(pin0));
  always #4 clk = ~clk;
  // Behavioural model of the mode register, the machine phase and the pin enables.
  always @(posedge clk) begin
    if (!resetn) begin
      m_n <= 0;
      m_mode <= sel;
      m_oe <= 1'b0;
    end else begin
      m_n <= m_n + 1;
      if (wr) m_mode <= wd;
      m_oe <= emu_n;
    end
  end
  always @(negedge clk) begin
    chk(8'(mode), 8'(m_mode));
    chk(8'(tick), 8'(m_n > 0 && m_n % CMTP_MACH_DIV == 0));
    chk(8'(mco), 8'(m_n > 0 && m_n % CMTP_MACH_DIV < CMTP_MACH_DIV / 2));
    chk({5'h00, mcoe, t0oe, t1oe}, {5'h00, m_oe, m_oe, m_oe});
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    sel = 3'h2;
    repeat (2) @(negedge clk);
    chk(8'(mode), 8'h05);
    wr = 1'b1;
    wd = 3'($random(seed));
    @(negedge clk) wr = 1'b0;
    repeat (2) @(negedge clk);
    chk(8'(mode), 8'(wd));
    osc_in = 1'($random(seed));
    repeat (2) @(negedge clk);
    chk({6'h00, src, xd}, {6'h00, osc_in, ~osc_in});
    osc = 1'b0;
    ext = 1'($random(seed));
    osc_in = ~ext;
    repeat (2) @(negedge clk);
    chk({6'h00, src, xd}, {6'h00, ext, 1'b0});
    for (k = 0; k < 8; k++) begin
      repeat (1 + ($random(seed) & 3)) @(negedge clk);
      u0 = 1'b1;
      u1 = 1'b1;
      @(negedge clk) u0 = 1'b0;
      u1 = 1'b0;
      w = pin0;
      v = t1;
      repeat (7) begin
        @(negedge clk) w += pin0;
        v += t1;
      end
      chk(8'(w), 8'(CMTP_MACH_DIV));
      chk(8'(v), 8'(CMTP_MACH_DIV));
    end
    w = 0;
    v = 0;
    repeat (8) begin
      @(negedge clk) w += tick;
      v += mco;
    end
    chk(8'(w), 8'(8 / CMTP_MACH_DIV));
    chk(8'(v), 8'(8 / CMTP_MACH_DIV * (CMTP_MACH_DIV / 2)));
    hen = 1'b1;
    for (k = 0; k < 6; k++) begin
      hin = 1'($random(seed));
      u1 = ~hin;
      @(negedge clk) chk(8'(t1), 8'(hin));
    end
    u1 = 1'b0;
    emu_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({5'h00, mcoe, t0oe, t1oe}, 8'h00);
    emu_n = 1'b1;
    repeat (2) @(negedge clk);
    chk({5'h00, mcoe, t0oe, t1oe}, 8'h07);
    resetn = 1'b0;
    sel = 3'($random(seed));
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    wd = sel;
    sel = ~sel;
    repeat (2) @(negedge clk);
    chk(8'(mode), 8'(wd));
    print_verdict();
  end
endmodule
